// ==== rtl/dcp_core.sv ====
// Purpose: debugger command interpreter, control and status registers
// Assumes: host bytes, memories and CPU all on clk; memory acks per byte
// Notes: a held memory request is completed by each memAck at its address
`timescale 1ns/100ps
module dcp_core #(
   parameter int unsigned PROG_BYTES = 65536
) (
   input  wire logic              clk,
   input  wire logic              rstn,
   input  wire logic              hostValid,
   input  wire logic [7:0]        hostData,
   output      logic              hostReady,
   output      logic              txValid,
   output      logic [7:0]        txData,
   input  wire logic              txReady,
   output      dcp_pkg::dcp_mem_t mem,
   input  wire logic              memAck,
   input  wire logic [7:0]        memRdata,
   output      dcp_pkg::dcp_cpu_t cpu,
   input  wire logic [2:0]        cpuInstrLen,
   input  wire logic              brkDecoded,
   input  wire logic              haltMode,
   input  wire logic              flashUnlocked,
   input  wire logic              readProtectOption,
   output      logic              debugHalt,
   output      logic              sysReset,
   input  wire logic              sysResetDone,
   output      logic [7:0]        debugControl,
   output      logic [7:0]        debugStatus
);
   dcp_pkg::dcp_state_t s_q;
   dcp_pkg::dcp_state_t s_d;
   logic                dbgOn;
   logic                cmdOk;
   logic                flashAddr;
   logic                wrOk;
   logic                rdOk;
   logic                txFree;
   logic                ctlWr;
   logic [7:0]          ctlVal;
   logic                adv;
   logic [15:0]         crcNext;

   // msb-first CCITT update, one byte per memory answer
   function automatic logic [15:0] crcByte(input logic [15:0] c, input logic [7:0] b);
      logic [15:0] r;
      logic        fb;
      r = c;
      for (int i = 7; i >= 0; i--) begin
         fb = r[15] ^ b[i];
         r  = {r[14:0], 1'b0} ^ (fb ? dcp_pkg::CRC_POLY : 16'h0000);
      end
      return r;
   endfunction

   assign dbgOn     = s_q.ctl[dcp_pkg::CTL_DBG_BIT];
   assign cmdOk     = dbgOn && !readProtectOption;
   assign flashAddr = (s_q.mem.addr[11:0] >= dcp_pkg::FLASH_CTL_LO)
                   && (s_q.mem.addr[11:0] <= dcp_pkg::FLASH_CTL_HI);
   assign wrOk = dbgOn && ((!readProtectOption                                    // RULE_08
                            && (s_q.mem.space != dcp_pkg::SP_PROG || flashUnlocked)) // RULE_06
                           || (s_q.mem.space == dcp_pkg::SP_REG && flashAddr));     // RULE_03
   assign rdOk = dbgOn && (s_q.mem.space == dcp_pkg::SP_DATA || !readProtectOption); // RULE_09
   assign txFree  = !s_q.txValid;
   assign crcNext = crcByte(s_q.crc, memRdata);

   always_comb begin
      s_d           = s_q;
      hostReady     = 1'b0;
      ctlWr         = 1'b0;
      ctlVal        = hostData;
      adv           = 1'b0;
      s_d.cpu.step  = 1'b0;
      s_d.cpu.stuff = 1'b0;
      s_d.cpu.execValid = 1'b0;
      if (s_q.txValid && txReady) begin
         s_d.txValid = 1'b0;
      end
      case (s_q.st)
         dcp_pkg::ST_IDLE: begin
            if (s_q.ackPend) begin
               // acknowledge goes out before the next command is taken
               if (txFree) begin
                  s_d.txValid = 1'b1;
                  s_d.txData  = dcp_pkg::FILL_BYTE;                        // RULE_18
                  s_d.ackPend = 1'b0;
               end
            end else begin
               hostReady = 1'b1;
               if (hostValid) begin
                  s_d.cmd  = hostData;
                  s_d.opnd = '0;
                  case (hostData)
                     dcp_pkg::CMD_STATUS: begin
                        s_d.resp = {8'h00, debugStatus};                   // RULE_21
                        s_d.st   = dcp_pkg::ST_TXLO;
                     end
                     dcp_pkg::CMD_CTL_RD: begin
                        s_d.resp = {8'h00, s_q.ctl};                       // RULE_21
                        s_d.st   = dcp_pkg::ST_TXLO;
                     end
                     dcp_pkg::CMD_CTL_WR, dcp_pkg::CMD_STUFF: begin
                        s_d.opLeft = dcp_pkg::OPND_ONE;
                        s_d.st     = dcp_pkg::ST_OPND;
                     end
                     dcp_pkg::CMD_REG_WR, dcp_pkg::CMD_REG_RD: begin
                        s_d.opLeft    = dcp_pkg::OPND_REG;                 // RULE_01
                        s_d.mem.space = dcp_pkg::SP_REG;
                        s_d.st        = dcp_pkg::ST_OPND;
                     end
                     dcp_pkg::CMD_PROG_WR, dcp_pkg::CMD_PROG_RD: begin
                        s_d.opLeft    = dcp_pkg::OPND_MEM;                 // RULE_05
                        s_d.mem.space = dcp_pkg::SP_PROG;
                        s_d.st        = dcp_pkg::ST_OPND;
                     end
                     dcp_pkg::CMD_DATA_WR, dcp_pkg::CMD_DATA_RD: begin
                        s_d.opLeft    = dcp_pkg::OPND_MEM;
                        s_d.mem.space = dcp_pkg::SP_DATA;
                        s_d.st        = dcp_pkg::ST_OPND;
                     end
                     dcp_pkg::CMD_CRC: begin
                        if (dbgOn) begin
                           s_d.mem.space = dcp_pkg::SP_PROG;
                           s_d.mem.addr  = 16'h0000;
                           s_d.mem.we    = 1'b0;
                           s_d.mem.req   = 1'b1;
                           s_d.cnt       = 17'(PROG_BYTES);
                           s_d.crc       = dcp_pkg::CRC_INIT;
                           s_d.st        = dcp_pkg::ST_CRC;
                        end else begin
                           s_d.resp = dcp_pkg::CRC_BLOCKED;                // RULE_10
                           s_d.st   = dcp_pkg::ST_TXHI;
                        end
                     end
                     dcp_pkg::CMD_STEP: begin
                        s_d.cpu.step = cmdOk;                              // RULE_12
                     end
                     dcp_pkg::CMD_EXEC: begin
                        s_d.st = dcp_pkg::ST_EXEC;
                     end
                     default: begin
                        s_d.st = dcp_pkg::ST_IDLE;                         // RULE_22
                     end
                  endcase
               end
            end
         end
         dcp_pkg::ST_OPND: begin
            hostReady = 1'b1;
            if (hostValid) begin
               s_d.opnd   = {s_q.opnd[15:0], hostData};
               s_d.opLeft = s_q.opLeft - 3'h1;
               if (s_q.opLeft == dcp_pkg::OPND_ONE) begin
                  s_d.st = s_q.cmd[0] ? dcp_pkg::ST_RD : dcp_pkg::ST_WR;
                  if (s_q.cmd == dcp_pkg::CMD_CTL_WR) begin
                     ctlWr  = 1'b1;                                        // RULE_21
                     s_d.st = dcp_pkg::ST_IDLE;
                  end else if (s_q.cmd == dcp_pkg::CMD_STUFF) begin
                     s_d.cpu.stuff = cmdOk;                                // RULE_13
                     s_d.cpu.data  = hostData;
                     s_d.st        = dcp_pkg::ST_IDLE;
                  end else if (s_q.mem.space == dcp_pkg::SP_REG) begin
                     s_d.mem.addr = {4'h0, s_q.opnd[11:0]};                // RULE_01
                     s_d.cnt = (hostData == 8'h00) ? dcp_pkg::SIZE_REG_ZERO
                                                   : {9'h000, hostData};   // RULE_02
                  end else begin
                     s_d.mem.addr = s_q.opnd[23:8];                        // RULE_05
                     s_d.cnt = ({s_q.opnd[7:0], hostData} == 16'h0000)
                             ? dcp_pkg::SIZE_MEM_ZERO
                             : {1'b0, s_q.opnd[7:0], hostData};            // RULE_07
                  end
               end
            end
         end
         dcp_pkg::ST_WR: begin
            if (s_q.mem.req) begin
               if (memAck) begin
                  s_d.mem.req = 1'b0;
                  adv = 1'b1;
               end
            end else begin
               hostReady = 1'b1;
               if (hostValid) begin
                  if (wrOk) begin
                     s_d.mem.req   = 1'b1;                                 // RULE_01
                     s_d.mem.we    = 1'b1;
                     s_d.mem.wdata = hostData;
                  end else begin
                     adv = 1'b1;                                           // RULE_03
                  end
               end
            end
         end
         dcp_pkg::ST_RD: begin
            if (s_q.mem.req) begin
               if (memAck) begin
                  s_d.mem.req = 1'b0;
                  s_d.txValid = 1'b1;
                  s_d.txData  = memRdata;
                  adv = 1'b1;
               end
            end else if (txFree) begin
               if (rdOk) begin
                  s_d.mem.req = 1'b1;
                  s_d.mem.we  = 1'b0;
               end else begin
                  s_d.txValid = 1'b1;
                  s_d.txData  = dcp_pkg::FILL_BYTE;                        // RULE_04
                  adv = 1'b1;
               end
            end
         end
         dcp_pkg::ST_CRC: begin
            // one byte per ack, so the answer waits one memAck per byte
            if (memAck) begin
               s_d.crc      = crcNext;                                     // RULE_10
               s_d.mem.addr = s_q.mem.addr + 16'h0001;
               s_d.cnt      = s_q.cnt - 17'h00001;
               if (s_q.cnt == 17'h00001) begin
                  s_d.mem.req = 1'b0;
                  s_d.resp    = crcNext;                                   // RULE_11
                  s_d.st      = dcp_pkg::ST_TXHI;
               end
            end
         end
         dcp_pkg::ST_TXHI: begin
            if (txFree) begin
               s_d.txValid = 1'b1;
               s_d.txData  = s_q.resp[15:8];
               s_d.st      = dcp_pkg::ST_TXLO;
            end
         end
         dcp_pkg::ST_TXLO: begin
            if (txFree) begin
               s_d.txValid = 1'b1;
               s_d.txData  = s_q.resp[7:0];
               s_d.st      = dcp_pkg::ST_IDLE;
            end
         end
         dcp_pkg::ST_EXEC: begin
            hostReady = 1'b1;
            if (hostValid) begin
               s_d.st = dcp_pkg::ST_IDLE;                                  // RULE_14
               if (cmdOk) begin
                  s_d.cpu.execValid = 1'b1;
                  s_d.cpu.data      = hostData;
                  s_d.st            = dcp_pkg::ST_EXLEN;
               end
            end
         end
         dcp_pkg::ST_EXLEN: begin
            // CPU decodes the first byte in the same cycle it is forwarded
            s_d.exLeft = cpuInstrLen - 3'h1;
            s_d.st = (cpuInstrLen <= 3'h1) ? dcp_pkg::ST_IDLE : dcp_pkg::ST_EXMORE;
         end
         dcp_pkg::ST_EXMORE: begin
            hostReady = 1'b1;
            if (hostValid) begin
               s_d.cpu.execValid = 1'b1;                                   // RULE_14
               s_d.cpu.data      = hostData;
               s_d.exLeft        = s_q.exLeft - 3'h1;
               if (s_q.exLeft == 3'h1) begin
                  s_d.st = dcp_pkg::ST_IDLE;
               end
            end
         end
         default: begin
            s_d.st = dcp_pkg::ST_IDLE;
         end
      endcase
      if (adv) begin
         s_d.mem.addr = s_q.mem.addr + 16'h0001;
         s_d.cnt      = s_q.cnt - 17'h00001;
         if (s_q.cnt == 17'h00001) begin
            s_d.st = dcp_pkg::ST_IDLE;
         end
      end
      if (ctlWr) begin
         s_d.ctl = ctlVal & dcp_pkg::CTL_WR_MASK;                          // RULE_15
         if (readProtectOption && dbgOn) begin
            s_d.ctl[dcp_pkg::CTL_DBG_BIT] = 1'b1;                          // RULE_16
         end
      end
      // reset end clears the bit unless the same cycle sets it again
      if (sysResetDone && !(ctlWr && ctlVal[dcp_pkg::CTL_RST_BIT])) begin
         s_d.ctl[dcp_pkg::CTL_RST_BIT] = 1'b0;                             // RULE_19
      end
      // breakpoint beats a clearing write in the same cycle
      if (brkDecoded && s_q.ctl[dcp_pkg::CTL_BRK_BIT]) begin
         s_d.ctl[dcp_pkg::CTL_DBG_BIT] = 1'b1;                             // RULE_17
         if (s_q.ctl[dcp_pkg::CTL_ACK_BIT]) begin
            s_d.ackPend = 1'b1;                                            // RULE_18
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s_q <= dcp_pkg::STATE_RESET;
      end else begin
         s_q <= s_d;
      end
   end
   assign txValid      = s_q.txValid;
   assign txData       = s_q.txData;
   assign mem          = s_q.mem;
   assign cpu          = s_q.cpu;
   assign debugHalt    = dbgOn;                                            // RULE_16
   assign sysReset     = s_q.ctl[dcp_pkg::CTL_RST_BIT];                    // RULE_19
   assign debugControl = s_q.ctl;
   always_comb begin
      debugStatus = 8'h00;
      debugStatus[dcp_pkg::STAT_DBG_BIT]  = dbgOn;                         // RULE_20
      debugStatus[dcp_pkg::STAT_HALT_BIT] = haltMode;
      debugStatus[dcp_pkg::STAT_PROT_BIT] = !readProtectOption;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   property p_prot_hold;
      readProtectOption && dbgOn |=> dbgOn;
   endproperty
   a_prot_hold: assert property (p_prot_hold) else $error("debug bit cleared under protect"); // RULE_16
   property p_brk_set;
      brkDecoded && s_q.ctl[dcp_pkg::CTL_BRK_BIT] |=> dbgOn;
   endproperty
   a_brk_set: assert property (p_brk_set) else $error("breakpoint did not enter debug"); // RULE_17
   property p_brk_ack;
      brkDecoded && s_q.ctl[dcp_pkg::CTL_BRK_BIT] && s_q.ctl[dcp_pkg::CTL_ACK_BIT]
         |=> ##[0:300] (txValid && txData == dcp_pkg::FILL_BYTE);
   endproperty
   a_brk_ack: assert property (p_brk_ack) else $error("breakpoint ack byte not sent"); // RULE_18
   property p_rst_clear;
      sysReset && sysResetDone && !ctlWr |=> !sysReset;
   endproperty
   a_rst_clear: assert property (p_rst_clear) else $error("reset bit did not self clear"); // RULE_19
   property p_rd_fill;
      s_q.st == dcp_pkg::ST_RD && !s_q.mem.req && txFree && !rdOk
         |=> txValid && txData == dcp_pkg::FILL_BYTE;
   endproperty
   a_rd_fill: assert property (p_rd_fill) else $error("blocked read not FFH"); // RULE_04
   property p_wr_debug;
      mem.req && mem.we |-> dbgOn;
   endproperty
   a_wr_debug: assert property (p_wr_debug) else $error("memory write outside debug"); // RULE_03
   property p_prog_lock;
      s_q.st == dcp_pkg::ST_WR && hostReady && hostValid && !flashUnlocked
         && s_q.mem.space == dcp_pkg::SP_PROG |=> !mem.req;
   endproperty
   a_prog_lock: assert property (p_prog_lock) else $error("locked flash written"); // RULE_06
   property p_step;
      s_q.st == dcp_pkg::ST_IDLE && hostReady && hostValid
         && hostData == dcp_pkg::CMD_STEP |=> cpu.step == $past(cmdOk);
   endproperty
   a_step: assert property (p_step) else $error("step pulse wrong"); // RULE_12
   property p_size_zero;
      s_q.st == dcp_pkg::ST_OPND && hostValid && s_q.opLeft == dcp_pkg::OPND_ONE
         && s_q.mem.space == dcp_pkg::SP_REG && s_q.cmd[3] && hostData == 8'h00
         && !s_q.cmd[2] |=> s_q.cnt == dcp_pkg::SIZE_REG_ZERO;
   endproperty
   a_size_zero: assert property (p_size_zero) else $error("size zero not 256"); // RULE_02

   c_crc: cover property (s_q.st == dcp_pkg::ST_CRC ##1 s_q.st == dcp_pkg::ST_TXHI);
   c_brk: cover property (brkDecoded && s_q.ctl[dcp_pkg::CTL_BRK_BIT]);
   c_regrd: cover property (s_q.st == dcp_pkg::ST_RD && memAck);
   c_exec: cover property (s_q.st == dcp_pkg::ST_EXMORE && cpu.execValid);

endmodule // dcp_core

// ==== rtl/dcp_pkg.sv ====
// Purpose: constants and types of the debug command processor
// Assumes: one system clock, byte stream from the serial link logic on that clock
// Notes: Function list below, one line each
// Function
// [RULE_01] register write: cmd, addr hi, addr lo, size, data
// [RULE_02] register size zero means 256 bytes
// [RULE_03] register write needs debug; protect allows flash regs
// [RULE_04] register read returns FFH when blocked
// [RULE_05] program write: 16-bit address, 16-bit size
// [RULE_06] program write needs unlocked flash, debug, no protect
// [RULE_07] program read, size zero 65536, blocked gives FFH
// [RULE_08] data write discarded outside debug or protected
// [RULE_09] data read FFH only outside debug mode
// [RULE_10] CRC-CCITT over program memory, FFFFH outside debug
// [RULE_11] CRC answer comes after one clock per byte; code waits one memAck per byte
// [RULE_12] step command ignored outside debug or protected
// [RULE_13] stuff replaces opcode byte, ignored when blocked
// [RULE_14] execute forwards whole instruction, blocked eats one byte
// [RULE_15] control writes 81H, 41H, 40H reset, go, run
// [RULE_16] debug bit halts CPU; protect forbids clearing it
// [RULE_17] enabled breakpoint opcode sets the debug bit
// [RULE_18] acknowledge enabled sends FFH on breakpoint
// [RULE_19] control bit 0 resets system, self-clears after
// [RULE_20] status: debug, halt, protect-inactive, zeros
// [RULE_21] 04H writes control, 05H reads it, 02H status
// [RULE_22] reserved command bytes are ignored
package dcp_pkg;

   localparam logic [7:0] CMD_STATUS  = 8'h02;
   localparam logic [7:0] CMD_CTL_WR  = 8'h04;
   localparam logic [7:0] CMD_CTL_RD  = 8'h05;
   localparam logic [7:0] CMD_REG_WR  = 8'h08;
   localparam logic [7:0] CMD_REG_RD  = 8'h09;
   localparam logic [7:0] CMD_PROG_WR = 8'h0a;
   localparam logic [7:0] CMD_PROG_RD = 8'h0b;
   localparam logic [7:0] CMD_DATA_WR = 8'h0c;
   localparam logic [7:0] CMD_DATA_RD = 8'h0d;
   localparam logic [7:0] CMD_CRC     = 8'h0e;
   localparam logic [7:0] CMD_STEP    = 8'h10;
   localparam logic [7:0] CMD_STUFF   = 8'h11;
   localparam logic [7:0] CMD_EXEC    = 8'h12;

   localparam int          CTL_DBG_BIT  = 7;
   localparam int          CTL_BRK_BIT  = 6;
   localparam int          CTL_ACK_BIT  = 5;
   localparam int          CTL_RST_BIT  = 0;
   localparam int          STAT_DBG_BIT  = 7;
   localparam int          STAT_HALT_BIT = 6;
   localparam int          STAT_PROT_BIT = 5;
   localparam logic [7:0]  CTL_RESET    = 8'h00;
   localparam logic [7:0]  CTL_WR_MASK  = 8'he1;
   localparam logic [7:0]  FILL_BYTE    = 8'hff;
   localparam logic [15:0] CRC_POLY     = 16'h1021;
   localparam logic [15:0] CRC_INIT     = 16'hffff;
   localparam logic [15:0] CRC_BLOCKED  = 16'hffff;
   localparam logic [11:0] FLASH_CTL_LO = 12'hff8;
   localparam logic [11:0] FLASH_CTL_HI = 12'hffb;
   localparam logic [2:0]  OPND_ONE     = 3'h1;
   localparam logic [2:0]  OPND_REG     = 3'h3;
   localparam logic [2:0]  OPND_MEM     = 3'h4;
   localparam logic [16:0] SIZE_REG_ZERO = 17'h00100;
   localparam logic [16:0] SIZE_MEM_ZERO = 17'h10000;

   typedef enum logic [1:0] {
      SP_REG  = 2'b00,
      SP_PROG = 2'b01,
      SP_DATA = 2'b10
   } dcp_space_t;

   typedef enum logic [3:0] {
      ST_IDLE   = 4'b0000,
      ST_OPND   = 4'b0001,
      ST_WR     = 4'b0010,
      ST_RD     = 4'b0011,
      ST_CRC    = 4'b0100,
      ST_TXHI   = 4'b0101,
      ST_TXLO   = 4'b0110,
      ST_EXEC   = 4'b0111,
      ST_EXLEN  = 4'b1000,
      ST_EXMORE = 4'b1001
   } dcp_st_t;

   typedef struct packed {
      logic        req;
      logic        we;
      dcp_space_t  space;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } dcp_mem_t;

   typedef struct packed {
      logic       step;
      logic       stuff;
      logic       execValid;
      logic [7:0] data;
   } dcp_cpu_t;

   typedef struct packed {
      dcp_st_t     st;
      logic [7:0]  cmd;
      logic [23:0] opnd;
      logic [2:0]  opLeft;
      logic [16:0] cnt;
      logic [7:0]  ctl;
      logic        ackPend;
      logic        txValid;
      logic [7:0]  txData;
      logic [15:0] resp;
      logic [15:0] crc;
      logic [2:0]  exLeft;
      dcp_mem_t    mem;
      dcp_cpu_t    cpu;
   } dcp_state_t;

   localparam dcp_state_t STATE_RESET = '0;

endpackage

// ==== test/dcp_mem_model.sv ====
// Purpose: memory responder behind the debugger memory port
// Assumes: one request held until memAck, one outstanding at a time
// Notes: slow adds wait states; idle read data is inverted to expose stale use
`timescale 1ns/100ps
module dcp_mem_model (
   input  wire logic              clk,
   input  wire logic              slow,
   input  wire dcp_pkg::dcp_mem_t mem,
   output      logic              memAck,
   output      logic [7:0]        memRdata
);
   logic [7:0] arr [16];
   logic [1:0] wait_q;

   initial begin
      foreach (arr[i]) arr[i] = 8'h00;
      memAck = 1'b0;
      wait_q = 2'h0;
   end

   // no ack in the ack cycle: the request is only dropped at that edge
   always @(posedge clk) begin
      memAck <= 1'b0;
      wait_q <= 2'h0;
      if (mem.req && !memAck) begin
         if (wait_q == (slow ? 2'h3 : 2'h0)) begin
            memAck <= 1'b1;
            if (mem.we) arr[mem.addr[3:0]] <= mem.wdata;
         end else begin
            wait_q <= wait_q + 2'h1;
         end
      end
   end

   assign memRdata = memAck ? arr[mem.addr[3:0]] : ~arr[mem.addr[3:0]];
endmodule // dcp_mem_model

// ==== test/debug_command_processor_tb.sv ====
// Purpose: self-checking bench of the debugger command interpreter
// Assumes: memory model answers on the memory port
// Notes: program size shortened to 16 bytes
`timescale 1ns/100ps
module debug_command_processor_tb;
   logic clk, rstn, hostValid, txReady, haltMode, rdProt, sysResetDone, slow;
   logic hostReady, txValid, memAck, debugHalt, sysReset;
   logic brkDecoded, flashUnlocked;
   logic [2:0] instrLen;
   logic [7:0] hostData, txData, memRdata, debugControl, debugStatus;
   dcp_pkg::dcp_mem_t mem;
   dcp_pkg::dcp_cpu_t cpu;
   int errorCnt = 0;
   int checkCount = 0;

   dcp_core #(.PROG_BYTES(16)) dcp_core_inst (.clk(clk), .rstn(rstn),
      .hostValid(hostValid), .hostData(hostData), .hostReady(hostReady),
      .txValid(txValid), .txData(txData), .txReady(txReady), .mem(mem),
      .memAck(memAck), .memRdata(memRdata), .cpu(cpu), .cpuInstrLen(instrLen),
      .brkDecoded(brkDecoded), .haltMode(haltMode), .flashUnlocked(flashUnlocked),
      .readProtectOption(rdProt), .debugHalt(debugHalt), .sysReset(sysReset),
      .sysResetDone(sysResetDone), .debugControl(debugControl),
      .debugStatus(debugStatus));

   dcp_mem_model dcp_mem_model_inst (.clk(clk), .slow(slow), .mem(mem),
      .memAck(memAck), .memRdata(memRdata));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic summarize;
      $display("errors %0d checks %0d", errorCnt, checkCount);
      if (errorCnt == 0 && checkCount > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   task automatic chk(string n, logic [7:0] e, logic [7:0] g);
      checkCount++;
      if (g !== e) begin
         errorCnt++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask

   // reference CRC over an all-zero program image of n bytes
   function automatic logic [15:0] crcRef(int n);
      logic [15:0] c;
      c = dcp_pkg::CRC_INIT;
      repeat (n * 8) c = {c[14:0], 1'b0} ^ (c[15] ? dcp_pkg::CRC_POLY : 16'h0000);
      return c;
   endfunction

   task automatic hang(string n);
      errorCnt++;
      $display("Error %s expected handshake seen none", n);
      summarize();
   endtask

   // byte held until hostReady is seen, then released to its inverse
   task automatic send(logic [7:0] b);
      int i;
      @(posedge clk);
      hostValid <= 1'b1;
      hostData <= b;
      for (i = 0; i < 400; i++) begin
         @(negedge clk);
         if (hostReady === 1'b1) break;
      end
      if (i == 400) hang("hostReady");
      @(posedge clk);
      hostValid <= 1'b0;
      hostData <= ~b;
   endtask

   task automatic sendq(logic [7:0] q[$]);
      foreach (q[k]) send(q[k]);
   endtask

   task automatic recv(string n, logic [7:0] e);
      int i;
      @(posedge clk);
      txReady <= 1'b1;
      for (i = 0; i < 400; i++) begin
         @(negedge clk);
         if (txValid === 1'b1) break;
      end
      if (i == 400) hang(n);
      chk(n, e, txData);
      @(posedge clk);
      txReady <= 1'b0;
   endtask

   task automatic t_reset;
      chk("control", 8'h00, debugControl);
      chk("status", 8'h20, debugStatus);
   endtask

   task automatic t_ctl;
      sendq('{8'h04, 8'h81});
      @(negedge clk);
      chk("control", 8'h81, debugControl);
      chk("halt", 8'h01, {7'h0, debugHalt});
      chk("sysReset", 8'h01, {7'h0, sysReset});
      @(posedge clk);
      sysResetDone <= 1'b1;
      @(posedge clk);
      sysResetDone <= 1'b0;
      @(negedge clk);
      chk("control", 8'h80, debugControl);
   endtask

   task automatic t_mem;
      logic [15:0] crc = crcRef(16);
      slow <= 1'b1;
      send(8'h0e);
      recv("crc hi", crc[15:8]);
      recv("crc lo", crc[7:0]);
      sendq('{8'h0c, 8'h00, 8'h10, 8'h00, 8'h01, 8'h5a});
      sendq('{8'h0d, 8'h00, 8'h10, 8'h00, 8'h01});
      recv("data read", 8'h5a);
      sendq('{8'h08, 8'h00, 8'h23, 8'h01, 8'h3c});
      sendq('{8'h09, 8'h00, 8'h23, 8'h01});
      recv("reg read", 8'h3c);
      sendq('{8'h0a, 8'h00, 8'h01, 8'h00, 8'h01, 8'h77});
      flashUnlocked <= 1'b1;
      sendq('{8'h0a, 8'h00, 8'h02, 8'h00, 8'h01, 8'h66});
      flashUnlocked <= 1'b0;
      sendq('{8'h0b, 8'h00, 8'h01, 8'h00, 8'h02});
      recv("prog read", 8'h00);
      recv("prog read", 8'h66);
      sendq('{8'h11, 8'h3c});
      @(negedge clk);
      chk("stuff", 8'h3c, cpu.stuff ? cpu.data : 8'h00);
      sendq('{8'h12, 8'h9f});
      @(negedge clk);
      chk("exec", 8'h9f, cpu.execValid ? cpu.data : 8'h00);
      send(8'h21);
      @(negedge clk);
      chk("exec", 8'h21, cpu.execValid ? cpu.data : 8'h00);
      send(8'h10);
      @(negedge clk);
      chk("step", 8'h01, {7'h0, cpu.step});
      slow <= 1'b0;
   endtask

   task automatic t_prot;
      rdProt <= 1'b1;
      haltMode <= 1'b1;
      send(8'h02);
      recv("status", 8'hc0);
      sendq('{8'h09, 8'h00, 8'h10, 8'h00});
      recv("reg read", 8'hff);
      repeat (255) recv("reg read", 8'hff);
      sendq('{8'h08, 8'h0f, 8'hfb, 8'h02, 8'hc3, 8'h99});
      sendq('{8'h0d, 8'h0f, 8'hfb, 8'h00, 8'h02});
      recv("flash reg", 8'hc3);
      recv("other reg", 8'h00);
      sendq('{8'h0d, 8'h00, 8'h10, 8'h00, 8'h01});
      recv("data read", 8'h5a);
      sendq('{8'h04, 8'h00, 8'h05});
      recv("control", 8'h80);
   endtask

   // reserved byte between write and read must leave control alone
   task automatic t_run;
      rdProt <= 1'b0;
      haltMode <= 1'b0;
      sendq('{8'h04, 8'h40, 8'h13, 8'h12, 8'h05, 8'h05});
      recv("control", 8'h40);
      @(negedge clk);
      chk("halt", 8'h00, {7'h0, debugHalt});
      send(8'h0e);
      recv("crc hi", 8'hff);
      recv("crc lo", 8'hff);
      sendq('{8'h04, 8'h60});
      @(posedge clk);
      brkDecoded <= 1'b1;
      @(posedge clk);
      brkDecoded <= 1'b0;
      recv("brk ack", 8'hff);
      send(8'h05);
      recv("control", 8'he0);
   endtask

   initial begin
      rstn = 1'b0;
      hostValid = 1'b0;
      hostData = 8'h00;
      txReady = 1'b0;
      haltMode = 1'b0;
      rdProt = 1'b0;
      sysResetDone = 1'b0;
      slow = 1'b0;
      brkDecoded = 1'b0;
      flashUnlocked = 1'b0;
      instrLen = 3'h2;
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      @(negedge clk);
      t_reset();
      t_ctl();
      t_mem();
      t_prot();
      t_run();
      summarize();
   end
endmodule // debug_command_processor_tb
